// *** verilog/isc_defines.vh ***
`ifndef ISC_DEFINES_VH
`define ISC_DEFINES_VH
// Instruction class codes presented on the class input
`define ISC_CLS_W 5
`define ISC_ADD_B_IMM 5'h00
`define ISC_ADD_B_REG 5'h01
`define ISC_ADD_W_IMM 5'h02
`define ISC_ADD_W_REG 5'h03
`define ISC_ADD_L_IMM 5'h04
`define ISC_ADD_L_REG 5'h05
`define ISC_ADD_SMALL 5'h06
`define ISC_ADDC_IMM 5'h07
`define ISC_ADDC_REG 5'h08
`define ISC_AND_B_IMM 5'h09
`define ISC_AND_B_REG 5'h0A
`define ISC_AND_W_IMM 5'h0B
`define ISC_AND_W_REG 5'h0C
`define ISC_AND_L_IMM 5'h0D
`define ISC_AND_L_REG 5'h0E
`define ISC_AND_FLAGS 5'h0F
`define ISC_BAND_REG 5'h10
`define ISC_BAND_IND 5'h11
`define ISC_BAND_ABS 5'h12
`define ISC_BRANCH8 5'h13
// Cycle counts per type
`define ISC_CNT_W 3
`define ISC_CNT0 3'h0
`define ISC_CNT1 3'h1
`define ISC_CNT2 3'h2
`define ISC_CNT3 3'h3
// Per-cycle state costs
`define ISC_ST_W 3
`define ISC_ST_MEM 3'h2
`define ISC_ST_PER_FAST 3'h2
`define ISC_ST_PER_SLOW 3'h3
`define ISC_ST_INT 3'h1
// Total width
`define ISC_TOT_W 8
`endif

// *** verilog/isc_counter.v ***
// What this block does
// [RQ1] Total equals sum of count times cost
// [RQ2] Fetch, branch read, stack in memory: 2
// [RQ3] Peripheral byte access costs 2 or 3
// [RQ4] Byte add/AND immediate: one fetch only
// [RQ5] Word immediate two fetches, register one
// [RQ6] Longword immediate: three fetches, nothing else
// [RQ7] Longword register AND 2, add 1
// [RQ8] Small add, carry add, flags AND: 1
// [RQ9] Bit-AND-carry: reg 1; memory 2+1 byte
// [RQ10] Short branches: two fetches, no internal
// [RQ11] Internal costs 1; zero counts add nothing
`timescale 1ns/1ns
`include "isc_defines.vh"
module isc_counter #(
  // Width of each cycle-type count
  parameter CNT_W = `ISC_CNT_W,
  // Width of one per-cycle state cost
  parameter ST_W = `ISC_ST_W,
  // Width of the state total; the largest class sum must fit in it
  parameter TOT_W = `ISC_TOT_W
) (
  // Core clock; every register below runs on each rising edge
  input wire mclk,
  // Synchronous reset, active low
  input wire rst_n,
  // One request per high cycle, from logic on this clock
  input wire req_valid,
  // Instruction class code, taken with the request
  input wire [`ISC_CLS_W-1:0] req_class,
  // High when the byte data access goes to a peripheral module
  input wire data_in_periph,
  // High when the addressed peripheral needs the longer byte access
  input wire periph_slow,
  // Answer strobe, one cycle after each request
  output reg ans_valid_q,
  // High when the last class taken was one this block knows
  output reg ans_known_q,
  // Instruction fetch cycles
  output reg [CNT_W-1:0] fetch_cnt_q,
  // Branch address read cycles
  output reg [CNT_W-1:0] branch_cnt_q,
  // Stack operation cycles
  output reg [CNT_W-1:0] stack_cnt_q,
  // Byte data access cycles
  output reg [CNT_W-1:0] byte_cnt_q,
  // Word data access cycles
  output reg [CNT_W-1:0] word_cnt_q,
  // Internal operation cycles
  output reg [CNT_W-1:0] int_cnt_q,
  // Total execution states of the last request
  output reg [TOT_W-1:0] states_q
);

  // Counts decoded from the class now presented
  reg [CNT_W-1:0] fetch_dec;
  reg [CNT_W-1:0] branch_dec;
  reg [CNT_W-1:0] stack_dec;
  reg [CNT_W-1:0] byte_dec;
  reg [CNT_W-1:0] word_dec;
  reg [CNT_W-1:0] int_dec;
  // Low when the class code is outside the table
  reg known_dec;
  // Per-cycle cost of a byte access at the addressed location
  reg [ST_W-1:0] byte_cost;
  // Weighted terms, one per cycle type
  reg [TOT_W-1:0] fetch_term;
  reg [TOT_W-1:0] branch_term;
  reg [TOT_W-1:0] stack_term;
  reg [TOT_W-1:0] byte_term;
  reg [TOT_W-1:0] word_term;
  reg [TOT_W-1:0] int_term;
  // Sum of the six terms
  reg [TOT_W-1:0] states_sum;
  // Next values of the answer registers
  reg ans_valid_d;
  reg ans_known_d;
  reg [CNT_W-1:0] fetch_cnt_d;
  reg [CNT_W-1:0] branch_cnt_d;
  reg [CNT_W-1:0] stack_cnt_d;
  reg [CNT_W-1:0] byte_cnt_d;
  reg [CNT_W-1:0] word_cnt_d;
  reg [CNT_W-1:0] int_cnt_d;
  reg [TOT_W-1:0] states_d;

  // Product of a count and a cost, both widened to the total width first
  // so that the multiply cannot wrap inside the narrower operands
  function [TOT_W-1:0] isc_weigh;
    input [CNT_W-1:0] cnt;
    input [ST_W-1:0] cost;
    begin
      isc_weigh = {{(TOT_W-CNT_W){1'h0}}, cnt} * {{(TOT_W-ST_W){1'h0}}, cost};
    end
  endfunction

  // Class decode into cycle counts; every count starts at zero so that
  // a class only names the cycle types it really uses
  always @* begin
    fetch_dec = `ISC_CNT0;
    branch_dec = `ISC_CNT0;
    stack_dec = `ISC_CNT0;
    byte_dec = `ISC_CNT0;
    word_dec = `ISC_CNT0;
    int_dec = `ISC_CNT0;
    known_dec = 1'h1;
    case (req_class)
      // Byte immediate forms: a single fetch, nothing else
      `ISC_ADD_B_IMM, `ISC_AND_B_IMM: begin
        fetch_dec = `ISC_CNT1; // [RQ4]
      end
      // Byte register forms
      `ISC_ADD_B_REG, `ISC_AND_B_REG: begin
        fetch_dec = `ISC_CNT1;
      end
      // Word immediate needs a second fetch for the operand
      `ISC_ADD_W_IMM, `ISC_AND_W_IMM: begin
        fetch_dec = `ISC_CNT2; // [RQ5]
      end
      // Word register forms fit in one fetch
      `ISC_ADD_W_REG, `ISC_AND_W_REG: begin
        fetch_dec = `ISC_CNT1; // [RQ5]
      end
      // Longword immediate: three fetches and no other cycles
      `ISC_ADD_L_IMM, `ISC_AND_L_IMM: begin
        fetch_dec = `ISC_CNT3; // [RQ6]
      end
      // Register to register longword add is short
      `ISC_ADD_L_REG: begin
        fetch_dec = `ISC_CNT1; // [RQ7]
      end
      // Register to register longword AND is a two-word instruction
      `ISC_AND_L_REG: begin
        fetch_dec = `ISC_CNT2; // [RQ7]
      end
      // Small constant add, carry add, AND into the flags
      `ISC_ADD_SMALL, `ISC_ADDC_IMM, `ISC_ADDC_REG, `ISC_AND_FLAGS: begin
        fetch_dec = `ISC_CNT1; // [RQ8]
      end
      // Bit AND to carry on a register operand
      `ISC_BAND_REG: begin
        fetch_dec = `ISC_CNT1; // [RQ9]
      end
      // Bit AND to carry on a memory operand reads one byte
      `ISC_BAND_IND, `ISC_BAND_ABS: begin
        fetch_dec = `ISC_CNT2; // [RQ9]
        byte_dec = `ISC_CNT1; // [RQ9]
      end
      // Taken or not, the short branch costs the same
      `ISC_BRANCH8: begin
        fetch_dec = `ISC_CNT2; // [RQ10]
      end
      // Unlisted classes answer zero and flag themselves unknown
      default: begin
        known_dec = 1'h0;
      end
    endcase
  end

  // Byte access cost at the addressed location; on-chip memory takes the
  // same base figure as a fetch, a peripheral module picks its own length
  always @* begin
    if (data_in_periph) begin
      // Peripheral module: the addressed module decides the length
      if (periph_slow) begin
        byte_cost = `ISC_ST_PER_SLOW; // [RQ3]
      end else begin
        byte_cost = `ISC_ST_PER_FAST; // [RQ3]
      end
    end else begin
      // On-chip memory
      byte_cost = `ISC_ST_MEM; // [RQ2]
    end
  end

  // Weight each count by its per-cycle cost; a zero count gives a zero term
  always @* begin
    fetch_term = isc_weigh(fetch_dec, `ISC_ST_MEM); // [RQ2]
    branch_term = isc_weigh(branch_dec, `ISC_ST_MEM); // [RQ2]
    stack_term = isc_weigh(stack_dec, `ISC_ST_MEM); // [RQ2]
    byte_term = isc_weigh(byte_dec, byte_cost); // [RQ3]
    // Word data only ever targets memory in the classes handled here
    word_term = isc_weigh(word_dec, `ISC_ST_MEM);
    int_term = isc_weigh(int_dec, `ISC_ST_INT); // [RQ11]
  end

  // Total of the six terms; all terms share one width, so nothing is cut
  always @* begin
    states_sum = fetch_term + branch_term + stack_term + byte_term + word_term + int_term; // [RQ1]
  end

  // Next answer: load on a request, otherwise hold the last answer so a
  // reader need not latch it; the strobe itself simply follows the request
  always @* begin
    ans_valid_d = req_valid;
    if (req_valid) begin
      // New request: take the decoded figures
      ans_known_d = known_dec;
      fetch_cnt_d = fetch_dec;
      branch_cnt_d = branch_dec;
      stack_cnt_d = stack_dec;
      byte_cnt_d = byte_dec;
      word_cnt_d = word_dec;
      int_cnt_d = int_dec;
      states_d = states_sum; // [RQ1]
    end else begin
      // Idle: keep what was answered last
      ans_known_d = ans_known_q;
      fetch_cnt_d = fetch_cnt_q;
      branch_cnt_d = branch_cnt_q;
      stack_cnt_d = stack_cnt_q;
      byte_cnt_d = byte_cnt_q;
      word_cnt_d = word_cnt_q;
      int_cnt_d = int_cnt_q;
      states_d = states_q;
    end
  end

  // Answer registers; every output comes straight from here
  always @(posedge mclk) begin
    if (!rst_n) begin
      // Reset clears the answer so no stale figure is shown
      ans_valid_q <= 1'h0;
      ans_known_q <= 1'h0;
      fetch_cnt_q <= `ISC_CNT0;
      branch_cnt_q <= `ISC_CNT0;
      stack_cnt_q <= `ISC_CNT0;
      byte_cnt_q <= `ISC_CNT0;
      word_cnt_q <= `ISC_CNT0;
      int_cnt_q <= `ISC_CNT0;
      states_q <= {TOT_W{1'h0}};
    end else begin
      ans_valid_q <= ans_valid_d;
      ans_known_q <= ans_known_d;
      fetch_cnt_q <= fetch_cnt_d;
      branch_cnt_q <= branch_cnt_d;
      stack_cnt_q <= stack_cnt_d;
      byte_cnt_q <= byte_cnt_d;
      word_cnt_q <= word_cnt_d;
      int_cnt_q <= int_cnt_d;
      states_q <= states_d; // [RQ1]
    end
  end
endmodule

// *** tb/isc_periph.sv ***
`timescale 1ns/1ns
// Bus far side: index 0 is on-chip memory, others are peripheral modules
module isc_periph (
  input wire [1:0] sel,
  output wire data_in_periph,
  output wire periph_slow
);
  // Memory never takes the slow path
  assign data_in_periph = sel != 2'h0;
  // Odd modules cost 3 states a byte, even ones 2
  assign periph_slow = sel[0];
endmodule

// *** tb/isc_counter_properties.sv ***
`timescale 1ns/1ns
`include "isc_defines.vh"
// Watches the counter through its ports only; the bench binds it in
module isc_chk (
  input wire mclk,
  input wire rst_n,
  input wire req_valid,
  input wire [4:0] req_class,
  input wire data_in_periph,
  input wire periph_slow,
  input wire ans_valid_q,
  input wire ans_known_q,
  input wire [2:0] fetch_cnt_q,
  input wire [2:0] int_cnt_q,
  input wire [7:0] states_q
);
  // Bit test classes with one byte access
  wire band_mem = req_class == `ISC_BAND_IND || req_class == `ISC_BAND_ABS;
  // One clock domain; nothing is judged while reset is low
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_answer_follows: assert property (req_valid |=> ans_valid_q) else $error("no answer");
  a_idle_quiet: assert property (!req_valid |=> !ans_valid_q && $stable(states_q)) else $error("idle move");
  a_long_imm: assert property (req_valid && req_class == `ISC_ADD_L_IMM |=>
    fetch_cnt_q == 3'h3 && states_q == 8'h06) else $error("long imm");
  a_long_and: assert property (req_valid && req_class == `ISC_AND_L_REG |=>
    states_q == 8'h04) else $error("long and");
  a_branch_two: assert property (req_valid && req_class == `ISC_BRANCH8 |=>
    fetch_cnt_q == 3'h2 && int_cnt_q == 3'h0) else $error("branch");
  a_byte_imm: assert property (req_valid && req_class == `ISC_AND_B_IMM |=>
    states_q == 8'h02) else $error("byte imm");
  a_slow_periph: assert property (req_valid && band_mem && data_in_periph && periph_slow |=>
    states_q == 8'h07) else $error("slow periph");
  a_fast_periph: assert property (req_valid && band_mem && data_in_periph && !periph_slow |=>
    states_q == 8'h06) else $error("fast periph");
  a_mem_byte: assert property (req_valid && band_mem && !data_in_periph |=>
    states_q == 8'h06) else $error("mem byte");
  // Codes past the last class answer zero states and flag themselves unknown
  a_unknown_zero: assert property (req_valid && req_class > `ISC_BRANCH8 |=>
    !ans_known_q && states_q == 8'h00) else $error("unknown class");
  cover property (req_valid ##1 req_valid);
  cover property (req_valid && band_mem && data_in_periph);
  cover property (req_valid && band_mem && data_in_periph && !periph_slow);
  cover property (ans_valid_q && !ans_known_q);
endmodule

// *** tb/isc_counter_test.sv ***
`timescale 1ns/1ns
`include "isc_defines.vh"
module isc_counter_test;
  reg mclk = 1'h0, rst_n = 1'h0, req_valid = 1'h0;
  reg [4:0] req_class = 5'h00;
  reg [1:0] sel = 2'h0; // Target chosen through the bus model
  wire data_in_periph, periph_slow, ans_valid_q, ans_known_q;
  wire [2:0] fetch_cnt_q, branch_cnt_q, stack_cnt_q, byte_cnt_q, word_cnt_q, int_cnt_q;
  wire [7:0] states_q;
  integer fail_count = 0, checks = 0, i;
  // Fetch count per class, class 0 leftmost; low 3 bits of each digit
  localparam [159:0] FE = "11213111111213211222";
  always #25 mclk = ~mclk;
  isc_periph isc_periph_i(.sel, .data_in_periph, .periph_slow);
  isc_counter isc_counter_i(.mclk, .rst_n, .req_valid, .req_class, .data_in_periph, .periph_slow, .ans_valid_q,
    .ans_known_q, .fetch_cnt_q, .branch_cnt_q, .stack_cnt_q, .byte_cnt_q, .word_cnt_q, .int_cnt_q, .states_q);
  task chk(input string n, input [7:0] s, input [7:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("ERROR %0s exp %0h seen %0h", n, e, s);
      end
    end
  endtask
  // Valid stays high, so successive calls run back to back
  task issue(input [4:0] c, input [1:0] s, input [7:0] st, input [2:0] f, input [2:0] b);
    begin
      @(posedge mclk);
      req_valid <= 1'h1;
      req_class <= c;
      sel <= s;
      @(posedge mclk);
      #1;
      chk("valid", ans_valid_q, 1'h1);
      chk("fetch", fetch_cnt_q, f);
      chk("byte", byte_cnt_q, b);
      chk("other", branch_cnt_q | stack_cnt_q | word_cnt_q | int_cnt_q, 3'h0);
      chk("states", states_q, st);
    end
  endtask
  task t_table;
    reg [2:0] f, b;
    begin
      for (i = 0; i < 20; i = i + 1) begin
        f = FE[8*(19-i) +: 3];
        b = {2'h0, i == 17 || i == 18};
        issue(i[4:0], 2'h0, {f, 1'h0} + {b, 1'h0}, f, b);
        chk("known", ans_known_q, 1'h1);
      end
    end
  endtask
  task t_periph;
    begin
      issue(`ISC_BAND_IND, 2'h1, 8'h07, 3'h2, 3'h1);
      issue(`ISC_BAND_ABS, 2'h2, 8'h06, 3'h2, 3'h1);
    end
  endtask
  task t_unknown;
    begin
      issue(5'h1F, 2'h3, 8'h00, 3'h0, 3'h0);
      chk("known", ans_known_q, 1'h0);
    end
  endtask
  // Reset in mid-run with a request standing: reset wins, then all stays clear
  task t_reset;
    begin
      @(posedge mclk);
      rst_n <= 1'h0;
      req_class <= `ISC_ADD_L_IMM;
      @(posedge mclk);
      #1;
      chk("rst valid", ans_valid_q, 1'h0);
      chk("rst fetch", fetch_cnt_q, 3'h0);
      chk("rst states", states_q, 8'h00);
      @(posedge mclk);
      req_valid <= 1'h0;
      @(posedge mclk);
      rst_n <= 1'h1;
      @(posedge mclk);
      #1;
      chk("rel valid", ans_valid_q, 1'h0);
      chk("rel known", ans_known_q, 1'h0);
      chk("rel states", states_q, 8'h00);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    t_table;
    t_reset;
    t_periph;
    t_unknown;
    @(posedge mclk);
    req_valid <= 1'h0;
    repeat (3) @(posedge mclk);
    close_out;
  end
endmodule
bind isc_counter isc_chk isc_chk_i(.mclk, .rst_n, .req_valid, .req_class, .data_in_periph, .periph_slow,
  .ans_valid_q, .ans_known_q, .fetch_cnt_q, .int_cnt_q, .states_q);
